// file: rfap_consts.vh
`ifndef RFAP_CONSTS_VH
`define RFAP_CONSTS_VH
// ----------------------------------------
// register layout
// ----------------------------------------
`define RFAP_DATA_W        32
// clear-only fields, one bit each
`define RFAP_CLR_POS       0
`define RFAP_CLR_W         4
// ordinary read/write field
`define RFAP_RW_POS        4
`define RFAP_RW_W          8
// legacy zero-category field
`define RFAP_LZ_POS        12
`define RFAP_LZ_W          4
// release-6 zero-category field
`define RFAP_ZR6_POS       16
`define RFAP_ZR6_W         4
// reset values
`define RFAP_RW_RST        8'h00
`define RFAP_CLR_RST       4'h0
`define RFAP_ZR6_RST       4'h0
`endif

// file: rfap_clear_bit.v
// ----------------------------------------
// one clear-only bit: hardware sets or clears, software clears only
// ----------------------------------------
module rfap_clear_bit
(
    input  wire clk_i,
    input  wire resetn_i,
    input  wire hw_set_i,
    input  wire hw_clr_i,
    input  wire sw_wr_i,
    input  wire sw_bit_i,
    output wire bit_o
);
    reg  bit_ff;
    reg  nxt_bit;

    always @*
    begin
        nxt_bit = bit_ff;
        if (sw_wr_i && !sw_bit_i)
        begin
            nxt_bit = 1'b0;
        end
        // nonzero software writes leave the bit alone
        if (hw_clr_i)
        begin
            nxt_bit = 1'b0;
        end
        if (hw_set_i)
        begin
            nxt_bit = 1'b1;
        end
    end

    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            bit_ff <= 1'b0;
        end
        else
        begin
            bit_ff <= nxt_bit;
        end
    end

    assign bit_o = bit_ff;
endmodule // rfap_clear_bit

// file: rfap_field_reg.v
`include "rfap_consts.vh"
// Overview of operation
// - with release-6 off, the legacy zero field reads zero and drops every write.
// - hardware never updates the release-6 zero field and treats it as zero for behaviour.
// - the release-6 zero field reads zero while all its writes were zero, and after a zero write.
// - hardware sets or clears a clear-only field; software can only clear it.
// - a nonzero software write into a clear-only field has no effect whatever.
// - a read of a clear-only bit returns its current hardware-kept state.
// - a dropped clear-only update does not stop writes to other fields of the register.
module rfap_field_reg
(
    input  wire                          clk_i,
    input  wire                          resetn_i,
    input  wire                          release6_i,
    input  wire                          wr_en_i,
    input  wire [`RFAP_DATA_W-1:0]       wr_data_i,
    input  wire [`RFAP_CLR_W-1:0]        hw_set_i,
    input  wire [`RFAP_CLR_W-1:0]        hw_clr_i,
    output reg  [`RFAP_DATA_W-1:0]       rd_data_o,
    output wire [`RFAP_CLR_W-1:0]        clr_state_o,
    output wire [`RFAP_RW_W-1:0]         rw_field_o,
    output wire                          zr6_nonzero_o
);
    // ----------------------------------------
    // write word slices
    // ----------------------------------------
    wire [`RFAP_CLR_W-1:0]  wr_clr;
    wire [`RFAP_RW_W-1:0]   wr_rw;
    wire [`RFAP_ZR6_W-1:0]  wr_zr6;

    // legacy zero bits are never sliced, so writes there vanish
    assign wr_clr = wr_data_i[`RFAP_CLR_POS +: `RFAP_CLR_W];
    assign wr_rw  = wr_data_i[`RFAP_RW_POS +: `RFAP_RW_W];
    assign wr_zr6 = wr_data_i[`RFAP_ZR6_POS +: `RFAP_ZR6_W];

    // ----------------------------------------
    // write qualifiers
    // ----------------------------------------
    wire                    rw_wr;
    wire                    zr6_wr;

    // rw update independent of the clear-only bits
    assign rw_wr  = wr_en_i;
    // release-6 zero field takes writes only in release-6 mode
    assign zr6_wr = wr_en_i & release6_i;

    // ----------------------------------------
    // rw field next value
    // ----------------------------------------
    reg  [`RFAP_RW_W-1:0]   rw_ff;
    reg  [`RFAP_RW_W-1:0]   nxt_rw;

    always @*
    begin
        nxt_rw = rw_ff;
        if (rw_wr)
        begin
            nxt_rw = wr_rw;
        end
    end

    // ----------------------------------------
    // rw field register
    // ----------------------------------------
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rw_ff <= `RFAP_RW_RST;
        end
        else
        begin
            rw_ff <= nxt_rw;
        end
    end

    // ----------------------------------------
    // release-6 zero field next value
    // ----------------------------------------
    reg  [`RFAP_ZR6_W-1:0]  zr6_ff;
    reg  [`RFAP_ZR6_W-1:0]  nxt_zr6;

    // no hardware source feeds this field
    always @*
    begin
        nxt_zr6 = zr6_ff;
        if (zr6_wr)
        begin
            nxt_zr6 = wr_zr6;
        end
    end

    // ----------------------------------------
    // release-6 zero field register
    // ----------------------------------------
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            zr6_ff <= `RFAP_ZR6_RST;
        end
        else
        begin
            zr6_ff <= nxt_zr6;
        end
    end

    // ----------------------------------------
    // clear-only bits
    // ----------------------------------------
    wire [`RFAP_CLR_W-1:0]  clr_bits;

    genvar gi;
    generate
        for (gi = 0; gi < `RFAP_CLR_W; gi = gi + 1)
        begin : g_clr
            rfap_clear_bit u_bit
            (
                .clk_i    (clk_i),
                .resetn_i (resetn_i),
                .hw_set_i (hw_set_i[gi]),
                .hw_clr_i (hw_clr_i[gi]),
                .sw_wr_i  (wr_en_i),
                .sw_bit_i (wr_clr[gi]),
                .bit_o    (clr_bits[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // release-6 zero field view
    // ----------------------------------------
    reg  [`RFAP_ZR6_W-1:0]  zr6_view;

    always @*
    begin
        zr6_view = {`RFAP_ZR6_W{1'b0}};
        if (release6_i)
        begin
            zr6_view = zr6_ff;
        end
    end

    // ----------------------------------------
    // read view
    // ----------------------------------------
    always @*
    begin
        rd_data_o = {`RFAP_DATA_W{1'b0}};
        rd_data_o[`RFAP_CLR_POS +: `RFAP_CLR_W] = clr_bits;
        rd_data_o[`RFAP_RW_POS +: `RFAP_RW_W]   = rw_ff;
        // legacy zero bits always read back as zero
        rd_data_o[`RFAP_LZ_POS +: `RFAP_LZ_W]   = {`RFAP_LZ_W{1'b0}};
        rd_data_o[`RFAP_ZR6_POS +: `RFAP_ZR6_W] = zr6_view;
    end

    // ----------------------------------------
    // status outputs
    // ----------------------------------------
    assign clr_state_o   = clr_bits;
    assign rw_field_o    = rw_ff;
    // behaviour treats the field as zero; flag only for visibility
    assign zr6_nonzero_o = |zr6_view;
endmodule // rfap_field_reg

// file: rfap_field_reg_props.sv
module rfap_field_reg_props
(
    input wire        clk_i,
    input wire        resetn_i,
    input wire        release6_i,
    input wire        wr_en_i,
    input wire [31:0] wr_data_i,
    input wire [3:0]  hw_set_i,
    input wire [3:0]  hw_clr_i,
    input wire [31:0] rd_data_o,
    input wire [3:0]  clr_state_o,
    input wire [7:0]  rw_field_o,
    input wire        zr6_nonzero_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    property p_hz; !wr_en_i |=> $stable(rd_data_o[19:16]) || $changed(release6_i); endproperty
    a_hz: assert property (p_hz) else $error("hz");
    property p_hs; |hw_set_i |=> &(clr_state_o | ~$past(hw_set_i)); endproperty
    a_hs: assert property (p_hs) else $error("hs");
    property p_sw; wr_en_i && ~|{hw_set_i, hw_clr_i}
        |=> clr_state_o == ($past(clr_state_o) & $past(wr_data_i[3:0])); endproperty
    a_sw: assert property (p_sw) else $error("sw");
    property p_ow; wr_en_i |=> rw_field_o == $past(wr_data_i[11:4]); endproperty
    a_ow: assert property (p_ow) else $error("ow");
    property p_lz; rd_data_o[31:20] == 12'h000 && rd_data_o[15:12] == 4'h0; endproperty
    a_lz: assert property (p_lz) else $error("legacy or unused read bits not zero");
    property p_rv; rd_data_o[3:0] == clr_state_o && rd_data_o[11:4] == rw_field_o; endproperty
    a_rv: assert property (p_rv) else $error("read view differs from stored fields");
    property p_r6; !release6_i |-> rd_data_o[19:16] == 4'h0 && !zr6_nonzero_o; endproperty
    a_r6: assert property (p_r6) else $error("release-6 zero field visible outside release-6 mode");
    property p_hc; |(hw_clr_i & ~hw_set_i) |=> (clr_state_o & $past(hw_clr_i) & ~$past(hw_set_i)) == 4'h0;
    endproperty
    a_hc: assert property (p_hc) else $error("hardware clear lost");
    property p_nr; ~|hw_set_i |=> (clr_state_o & ~$past(clr_state_o)) == 4'h0; endproperty
    a_nr: assert property (p_nr) else $error("clear-only bit rose without hardware set");
    cover property (wr_en_i);
    cover property (|hw_set_i);
    cover property (release6_i);
    cover property (|(hw_set_i & hw_clr_i));
endmodule // rfap_field_reg_props
bind rfap_field_reg rfap_field_reg_props u_props
(
    .clk_i         (clk_i),
    .resetn_i      (resetn_i),
    .release6_i    (release6_i),
    .wr_en_i       (wr_en_i),
    .wr_data_i     (wr_data_i),
    .hw_set_i      (hw_set_i),
    .hw_clr_i      (hw_clr_i),
    .rd_data_o     (rd_data_o),
    .clr_state_o   (clr_state_o),
    .rw_field_o    (rw_field_o),
    .zr6_nonzero_o (zr6_nonzero_o)
);

// file: tb_register_field_access_policy.sv
module tb_register_field_access_policy;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int N_RAND      = 300;
    localparam int WATCHDOG_NS = (N_RAND + 100) * 40;
    logic clk_i = 0, resetn_i = 0, release6_i = 0, wr_en_i = 0, zr6_nonzero_o;
    logic [31:0] wr_data_i = 0, rd_data_o;
    logic [3:0] hw_set_i = 0, hw_clr_i = 0, clr_state_o;
    logic [7:0] rw_field_o;
    logic [11:0] m = 0;
    int n_errors = 0, n_checks = 0;
    rfap_field_reg uut
    (
        .clk_i         (clk_i),
        .resetn_i      (resetn_i),
        .release6_i    (release6_i),
        .wr_en_i       (wr_en_i),
        .wr_data_i     (wr_data_i),
        .hw_set_i      (hw_set_i),
        .hw_clr_i      (hw_clr_i),
        .rd_data_o     (rd_data_o),
        .clr_state_o   (clr_state_o),
        .rw_field_o    (rw_field_o),
        .zr6_nonzero_o (zr6_nonzero_o)
    );
    always #20 clk_i = ~clk_i;
    // next clear-only and rw state: set beats clear beats a software zero write
    function automatic logic [11:0] exp_next(logic [11:0] cur, logic [3:0] s, c, logic w, logic [11:0] d);
        return {w ? d[11:4] : cur[11:4], s | ~c & cur[3:0] & (w ? d[3:0] : 4'hf)};
    endfunction
    task automatic check(string name, logic [31:0] exp, got);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic step(logic [3:0] s, c, logic w, logic [11:0] d);
        @(negedge clk_i);
        check("rd_data_o", {20'h0, m}, rd_data_o);
        check("clr_state_o", 32'(m[3:0]), 32'(clr_state_o));
        check("rw_field_o", 32'(m[11:4]), 32'(rw_field_o));
        check("zr6_nonzero_o", 32'h0, 32'(zr6_nonzero_o));
        {hw_set_i, hw_clr_i, wr_en_i, release6_i, wr_data_i} = {s, c, w, 1'($urandom), 20'h0, d};
        m = exp_next(m, s, c, w, d);
    endtask
    task finish_test();
        $display("%0d checks %0d errors", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        void'($urandom(4007));
        repeat (10) @(negedge clk_i);
        resetn_i = 1;
        repeat (N_RAND) step(4'($urandom), 4'($urandom), 1'($urandom), 12'($urandom));
        $display("random test done");
        step(4'h5, 4'h0, 1'b0, 12'h000);
        step(4'h0, 4'h0, 1'b1, 12'hff5);
        step(4'hf, 4'hf, 1'b1, 12'h000);
        step(4'h0, 4'h0, 1'b0, 12'h000);
        resetn_i = 0;
        m = 0;
        @(negedge clk_i);
        resetn_i = 1;
        step(4'h0, 4'h0, 1'b1, 12'h0a0);
        step(4'h0, 4'h0, 1'b0, 12'h000);
        $display("directed test done");
        finish_test();
    end
    initial
    begin
        #(WATCHDOG_NS);
        n_errors++;
        finish_test();
    end
endmodule // tb_register_field_access_policy
